/* common/flow_pkg.sv */
`default_nettype none

package flow_pkg;

	localparam int PC_W     = 13;
	localparam int DATA_W   = 8;
	localparam int ADDR_W   = 8;
	localparam int TGT_W    = 11;
	localparam int LATCH_W  = 5;
	localparam int SP_W     = 3;
	localparam int DEPTH    = 8;
	localparam int FETCH_W  = 11;

	localparam logic [ADDR_W-1:0] OFS_INTCTL  = 8'h0B;
	localparam logic [ADDR_W-1:0] OFS_PFLAG   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_OPTION  = 8'h81;
	localparam logic [ADDR_W-1:0] OFS_PCLOW   = 8'h82;
	localparam logic [ADDR_W-1:0] OFS_PCLATCH = 8'h8A;
	localparam logic [ADDR_W-1:0] OFS_PENABLE = 8'h8C;
	localparam logic [ADDR_W-1:0] OFS_RSTCAUS = 8'h8E;

	localparam int BIT_GLOBAL_EN  = 7;
	localparam int BIT_PERIPH_EN  = 6;
	localparam int BIT_ADC        = 6;
	localparam int BIT_PRESCALER  = 3;
	localparam int BIT_PARCFG     = 7;
	localparam int BIT_PARITY_RST = 2;
	localparam int BIT_POR        = 1;
	localparam int BIT_BROWNOUT   = 0;
	localparam int BIT_PAGE_LO    = 3;

	localparam logic [DATA_W-1:0]  RST_INTCTL  = 8'h00;
	localparam logic [DATA_W-1:0]  RST_OPTION  = 8'hFF;
	localparam logic [LATCH_W-1:0] RST_LATCH   = 5'h00;
	localparam logic [PC_W-1:0]    RST_PC      = 13'h0000;
	localparam logic [PC_W-1:0]    IRQ_VECTOR  = 13'h0004;
	localparam logic [SP_W-1:0]    RST_SP      = 3'h0;
	localparam logic [PC_W-1:0]    PC_ONE      = 13'h0001;
	localparam logic [SP_W-1:0]    SP_ONE      = 3'h1;
	localparam logic [DATA_W-1:0]  RD_ZERO     = 8'h00;

	typedef enum logic [2:0] {
		OP_HOLD   = 3'b000,
		OP_STEP   = 3'b001,
		OP_CALL   = 3'b010,
		OP_JUMP   = 3'b011,
		OP_RETURN = 3'b100,
		OP_IRQ    = 3'b101
	} pc_op_t;

	typedef struct packed {
		pc_op_t             op;
		logic [TGT_W-1:0]   target;
	} core_cmd_t;

	typedef struct packed {
		logic power_on;
		logic brown_out;
		logic parity_err;
	} rst_cause_t;

endpackage : flow_pkg

`default_nettype wire

/* logic/program_flow_and_irq_status_regs.sv */
// Overview of operation
// - 13-bit pc, low byte software read/write
// - upper pc bits unreadable, written via latch
// - every reset clears upper pc bits
// - low byte write loads latch bits 4:0
// - call/jump take top bits from latch 4:3
// - eight-entry stack of 13-bit words
// - stack and pointer invisible to software
// - call and irq vectoring push pc
// - return variants pop into pc
// - push and pop leave latch alone
// - stack wraps, ninth push overwrites first
// - no overflow or underflow status
// - paging bits ignored by fetch address
// - flags set regardless of enables
// - peripheral request needs peripheral_irq_enable
// - enable reg has only adc_irq_enable bit 6
// - flag reg has only adc_irq_flag bit 6
// - power-on clears power_on_reset_flag
// - brown-out clears brownout_reset_flag
// - parity reset clears flag, bit 7 mirrors config
// - prescaler_assign gives timer0 1:1 rate
`timescale 1ns/1ps
`default_nettype none

module program_flow_and_irq_status_regs (
	input  wire logic                        clk_i,
	input  wire logic                        srst_i,
	input  wire flow_pkg::rst_cause_t        rst_cause_i,
	input  wire logic                        parity_check_enabled_i,
	input  wire flow_pkg::core_cmd_t         core_cmd_i,
	input  wire logic                        adc_done_i,
	input  wire logic [flow_pkg::ADDR_W-1:0] reg_addr_i,
	input  wire logic [flow_pkg::DATA_W-1:0] reg_wdata_i,
	input  wire logic                        reg_wr_i,
	input  wire logic                        reg_rd_i,
	output logic      [flow_pkg::DATA_W-1:0] reg_rdata_o,
	output logic      [flow_pkg::PC_W-1:0]   pc_o,
	output logic      [flow_pkg::FETCH_W-1:0] fetch_addr_o,
	output logic                             global_irq_enable_o,
	output logic                             periph_irq_request_o,
	output logic                             prescaler_to_wdt_o,
	output logic                             timer0_rate_1to1_o
);

	logic [flow_pkg::PC_W-1:0]    pc_r;
	logic [flow_pkg::PC_W-1:0]    pc_nxt;
	logic [flow_pkg::LATCH_W-1:0] latch_r;
	logic [flow_pkg::DATA_W-1:0]  intctl_r;
	logic [flow_pkg::DATA_W-1:0]  option_r;
	logic                         adc_ie_r;
	logic                         adc_if_r;
	logic                         por_flag_r;
	logic                         brownout_flag_r;
	logic                         parity_flag_r;
	logic                         parcfg_r;
	logic [flow_pkg::SP_W-1:0]    sp_r;
	logic [flow_pkg::PC_W-1:0]    stack_r [flow_pkg::DEPTH];
	logic [flow_pkg::SP_W-1:0]    sp_dec;
	logic                         push;
	logic                         pop;
	logic [flow_pkg::PC_W-1:0]    push_val;
	logic [flow_pkg::DATA_W-1:0]  rd_mux;

	function automatic logic wr_hit(input logic [flow_pkg::ADDR_W-1:0] ofs);
		wr_hit = reg_wr_i && (reg_addr_i == ofs);
	endfunction : wr_hit

	// stack actions are driven only by the core; no register reaches them
	assign sp_dec   = sp_r - flow_pkg::SP_ONE;
	assign push     = (core_cmd_i.op == flow_pkg::OP_CALL)
	                  || (core_cmd_i.op == flow_pkg::OP_IRQ);
	assign pop      = (core_cmd_i.op == flow_pkg::OP_RETURN);
	// a call saves the next instruction, an interrupt the one it displaced
	assign push_val = (core_cmd_i.op == flow_pkg::OP_CALL) ? pc_r + flow_pkg::PC_ONE : pc_r;

	always_comb
	begin
		pc_nxt = pc_r;
		unique case (core_cmd_i.op)
			flow_pkg::OP_HOLD:
			begin
				pc_nxt = pc_r;
			end
			flow_pkg::OP_STEP:
			begin
				pc_nxt = pc_r + flow_pkg::PC_ONE;
			end
			flow_pkg::OP_CALL, flow_pkg::OP_JUMP:
			begin
				pc_nxt = {latch_r[flow_pkg::LATCH_W-1:flow_pkg::BIT_PAGE_LO],
				          core_cmd_i.target};
			end
			flow_pkg::OP_RETURN:
			begin
				pc_nxt = stack_r[sp_dec];
			end
			flow_pkg::OP_IRQ:
			begin
				pc_nxt = flow_pkg::IRQ_VECTOR;
			end
			default:
			begin
				pc_nxt = pc_r;
			end
		endcase
		// a software write to the low byte outranks the core in the same cycle
		if (wr_hit(flow_pkg::OFS_PCLOW))
		begin
			pc_nxt = {latch_r, reg_wdata_i};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			pc_r <= flow_pkg::RST_PC;
		end
		else
		begin
			pc_r <= pc_nxt;
		end
	end

	// only bits 4:0 are stored; the upper three read back as zero
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			latch_r <= flow_pkg::RST_LATCH;
		end
		else if (wr_hit(flow_pkg::OFS_PCLATCH))
		begin
			latch_r <= reg_wdata_i[flow_pkg::LATCH_W-1:0];
		end
	end

	// no full or empty tracking: wrap and underflow pass silently
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			sp_r <= flow_pkg::RST_SP;
		end
		else if (push)
		begin
			sp_r <= sp_r + flow_pkg::SP_ONE;
		end
		else if (pop)
		begin
			sp_r <= sp_dec;
		end
	end

	// entries are not cleared at reset; an unbalanced return reads stale data
	generate
		for (genvar i = 0; i < flow_pkg::DEPTH; i++)
		begin : g_stack
			always_ff @(posedge clk_i)
			begin
				if (!srst_i && push && (sp_r == flow_pkg::SP_W'(i)))
				begin
					stack_r[i] <= push_val;
				end
			end
		end
	endgenerate

	// all eight bits are plain storage here; the other sources live elsewhere
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			intctl_r <= flow_pkg::RST_INTCTL;
		end
		else if (wr_hit(flow_pkg::OFS_INTCTL))
		begin
			intctl_r <= reg_wdata_i;
		end
	end

	// only the prescaler bit is used in this block; the rest feed the timers
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			option_r <= flow_pkg::RST_OPTION;
		end
		else if (wr_hit(flow_pkg::OFS_OPTION))
		begin
			option_r <= reg_wdata_i;
		end
	end

	// written bits other than bit 6 are dropped, so they read zero
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			adc_ie_r <= 1'b0;
		end
		else if (wr_hit(flow_pkg::OFS_PENABLE))
		begin
			adc_ie_r <= reg_wdata_i[flow_pkg::BIT_ADC];
		end
	end

	// the conversion event wins over a software clear in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			adc_if_r <= 1'b0;
		end
		else if (adc_done_i)
		begin
			adc_if_r <= 1'b1;
		end
		else if (wr_hit(flow_pkg::OFS_PFLAG))
		begin
			adc_if_r <= reg_wdata_i[flow_pkg::BIT_ADC];
		end
	end

	// reset-cause flags: a cause clears its own flag; power-on also clears brown-out and sets parity, other causes keep the rest
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			if (rst_cause_i.power_on)
			begin
				por_flag_r      <= 1'b0;
				// cleared rather than left unknown, so software sees a defined value
				brownout_flag_r <= 1'b0;
				parity_flag_r   <= 1'b1;
			end
			else
			begin
				if (rst_cause_i.brown_out)
				begin
					brownout_flag_r <= 1'b0;
				end
				if (rst_cause_i.parity_err)
				begin
					parity_flag_r <= 1'b0;
				end
			end
		end
		else if (wr_hit(flow_pkg::OFS_RSTCAUS))
		begin
			por_flag_r      <= reg_wdata_i[flow_pkg::BIT_POR];
			brownout_flag_r <= reg_wdata_i[flow_pkg::BIT_BROWNOUT];
			parity_flag_r   <= reg_wdata_i[flow_pkg::BIT_PARITY_RST];
		end
	end

	// registered copy of the config bit: reads zero during reset, one cycle late
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			parcfg_r <= 1'b0;
		end
		else
		begin
			parcfg_r <= parity_check_enabled_i;
		end
	end

	// the stack pointer and entries have no address: they never reach this mux
	always_comb
	begin
		rd_mux = flow_pkg::RD_ZERO;
		unique case (reg_addr_i)
			flow_pkg::OFS_INTCTL:
			begin
				rd_mux = intctl_r;
			end
			flow_pkg::OFS_PFLAG:
			begin
				rd_mux[flow_pkg::BIT_ADC] = adc_if_r;
			end
			flow_pkg::OFS_OPTION:
			begin
				rd_mux = option_r;
			end
			flow_pkg::OFS_PCLOW:
			begin
				rd_mux = pc_r[flow_pkg::DATA_W-1:0];
			end
			flow_pkg::OFS_PCLATCH:
			begin
				rd_mux[flow_pkg::LATCH_W-1:0] = latch_r;
			end
			flow_pkg::OFS_PENABLE:
			begin
				rd_mux[flow_pkg::BIT_ADC] = adc_ie_r;
			end
			flow_pkg::OFS_RSTCAUS:
			begin
				rd_mux[flow_pkg::BIT_PARCFG] = parcfg_r;
				rd_mux[flow_pkg::BIT_PARITY_RST] = parity_flag_r;
				rd_mux[flow_pkg::BIT_POR]        = por_flag_r;
				rd_mux[flow_pkg::BIT_BROWNOUT]   = brownout_flag_r;
			end
			default:
			begin
				rd_mux = flow_pkg::RD_ZERO;
			end
		endcase
	end

	// read data stand for one cycle only and are zero otherwise
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			reg_rdata_o <= flow_pkg::RD_ZERO;
		end
		else if (reg_rd_i)
		begin
			reg_rdata_o <= rd_mux;
		end
		else
		begin
			reg_rdata_o <= flow_pkg::RD_ZERO;
		end
	end

	assign pc_o                 = pc_r;
	// only 2K words are fitted, so the paging bits never reach the fetch
	assign fetch_addr_o         = pc_r[flow_pkg::FETCH_W-1:0];
	assign global_irq_enable_o  = intctl_r[flow_pkg::BIT_GLOBAL_EN];
	// the request is a level; the core decides when to vector on it
	assign periph_irq_request_o = intctl_r[flow_pkg::BIT_PERIPH_EN] && adc_ie_r && adc_if_r;
	assign prescaler_to_wdt_o   = option_r[flow_pkg::BIT_PRESCALER];
	assign timer0_rate_1to1_o   = option_r[flow_pkg::BIT_PRESCALER];

endmodule : program_flow_and_irq_status_regs

`default_nettype wire

/* tb/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input  wire logic                go_i,
	input  wire flow_pkg::pc_op_t    op_i,
	input  wire logic [10:0]         tgt_i,
	output wire flow_pkg::core_cmd_t cmd_o
);
	// hold between ops so the pc never drifts while software works
	assign cmd_o = go_i ? {op_i, tgt_i} : {flow_pkg::OP_HOLD, 11'h000};
endmodule : core_model
`default_nettype wire

/* tb/flow_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module flow_asserts (
	input wire logic                         clk_i,
	input wire logic                         srst_i,
	input wire flow_pkg::core_cmd_t          core_cmd_i,
	input wire logic [flow_pkg::ADDR_W-1:0]  reg_addr_i,
	input wire logic [flow_pkg::DATA_W-1:0]  reg_wdata_i,
	input wire logic                         reg_wr_i,
	input wire logic [flow_pkg::PC_W-1:0]    pc_o,
	input wire logic [flow_pkg::FETCH_W-1:0] fetch_addr_o,
	input wire logic                         periph_irq_request_o,
	input wire logic                         prescaler_to_wdt_o,
	input wire logic                         timer0_rate_1to1_o
);
	// a software pc write overrides the core op, so branch checks skip it
	wire logic pcw = reg_wr_i && reg_addr_i == flow_pkg::OFS_PCLOW;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	AST_RESET_PC: assert property ($fell(srst_i) |-> pc_o == flow_pkg::RST_PC)
		else $error("pc not cleared by reset");
	AST_BRANCH: assert property (core_cmd_i.op inside {flow_pkg::OP_CALL, flow_pkg::OP_JUMP}
		&& !pcw |=> pc_o[10:0] == $past(core_cmd_i.target)) else $error("branch target lost");
	AST_IRQ_VEC: assert property (core_cmd_i.op == flow_pkg::OP_IRQ && !pcw
		|=> pc_o == flow_pkg::IRQ_VECTOR) else $error("irq vector wrong");
	AST_PCL_WR: assert property (pcw |=> pc_o[7:0] == $past(reg_wdata_i))
		else $error("pc low write lost");
	AST_FETCH: assert property (fetch_addr_o == pc_o[10:0])
		else $error("fetch address wrong");
	AST_CALL_RET: assert property ((core_cmd_i.op == flow_pkg::OP_CALL && !pcw)
		##1 (core_cmd_i.op == flow_pkg::OP_RETURN && !pcw)
		|=> pc_o == $past(pc_o, 2) + flow_pkg::PC_ONE) else $error("return address wrong");
	AST_REQ_OFF: assert property (reg_wr_i && reg_addr_i == flow_pkg::OFS_INTCTL
		&& !reg_wdata_i[flow_pkg::BIT_PERIPH_EN] |=> !periph_irq_request_o)
		else $error("request without peripheral enable");
	AST_OPTION: assert property (reg_wr_i && reg_addr_i == flow_pkg::OFS_OPTION
		|=> prescaler_to_wdt_o == $past(reg_wdata_i[flow_pkg::BIT_PRESCALER])
		&& timer0_rate_1to1_o == prescaler_to_wdt_o) else $error("prescaler output wrong");
	cover property (core_cmd_i.op == flow_pkg::OP_CALL ##1 core_cmd_i.op == flow_pkg::OP_RETURN);
	cover property (core_cmd_i.op == flow_pkg::OP_IRQ);
	cover property ($rose(periph_irq_request_o));
endmodule : flow_asserts
`default_nettype wire

/* tb/test_program_flow_and_irq_status_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_program_flow_and_irq_status_regs;
	logic                 clk_i = 1'b0;
	logic                 srst_i = 1'b1;
	flow_pkg::rst_cause_t cause = 3'b100;
	logic                 pce = 1'b1, adc = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
	logic [7:0]           addr = 8'h00, wdata = 8'h00, rdata;
	flow_pkg::pc_op_t     op = flow_pkg::OP_HOLD;
	logic [10:0]          tgt = 11'h000, fetch;
	logic [12:0]          pc;
	flow_pkg::core_cmd_t  cmd_w;
	logic                 global_irq_enable, req, prescaler_assign, t0;
	int                   error_cnt = 0, checks_done = 0, cyc = 0, i;
	initial forever #2.5 clk_i = ~clk_i;
	core_model core_u (.go_i(go), .op_i(op), .tgt_i(tgt), .cmd_o(cmd_w));
	program_flow_and_irq_status_regs DUT (.clk_i(clk_i), .srst_i(srst_i), .rst_cause_i(cause),
		.parity_check_enabled_i(pce), .core_cmd_i(cmd_w), .adc_done_i(adc), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .pc_o(pc),
		.fetch_addr_o(fetch), .global_irq_enable_o(global_irq_enable), .periph_irq_request_o(req),
		.prescaler_to_wdt_o(prescaler_assign), .timer0_rate_1to1_o(t0));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
		#1;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rd_chk
	task automatic cmd(input flow_pkg::pc_op_t o, input logic [10:0] t);
		@(posedge clk_i);
		go <= 1'b1;
		op <= o;
		tgt <= t;
		@(posedge clk_i);
		go <= 1'b0;
		#1;
	endtask : cmd
	task automatic do_reset(input flow_pkg::rst_cause_t c);
		@(posedge clk_i);
		srst_i <= 1'b1;
		cause <= c;
		repeat (16) @(posedge clk_i);
		srst_i <= 1'b0;
		cause <= 3'b000;
		#1;
	endtask : do_reset
	task automatic adc_pulse();
		@(posedge clk_i);
		adc <= 1'b1;
		@(posedge clk_i);
		adc <= 1'b0;
		#1;
	endtask : adc_pulse
	task automatic t_causes();
		rd_chk(8'h8E, 8'h84);
		rd_chk(8'h81, 8'hFF);
		rd_chk(8'h55, 8'h00);
		wr_reg(8'h8E, 8'h07);
		do_reset(3'b010);
		rd_chk(8'h8E, 8'h86);
		wr_reg(8'h8E, 8'h07);
		do_reset(3'b001);
		rd_chk(8'h8E, 8'h83);
		// the mirror bit must follow the config input down as well
		@(posedge clk_i);
		pce <= 1'b0;
		rd_chk(8'h8E, 8'h03);
		@(posedge clk_i);
		pce <= 1'b1;
		$display("test causes done");
	endtask : t_causes
	task automatic t_pc_write();
		wr_reg(8'h8A, 8'h1F);
		wr_reg(8'h82, 8'h10);
		chk(pc, 13'h1F10);
		chk(fetch, 11'h710);
		rd_chk(8'h82, 8'h10);
		do_reset(3'b000);
		chk(pc, 13'h0000);
		$display("test pc_write done");
	endtask : t_pc_write
	task automatic t_stack();
		wr_reg(8'h8A, 8'h08);
		for (i = 0; i < 9; i++)
		begin
			cmd(flow_pkg::OP_CALL, 11'h100 + i[10:0]);
			chk(pc, 13'h0900 + i[12:0]);
		end
		// ninth pop finds the ninth push again: silent wrap
		for (i = 0; i < 9; i++)
		begin
			cmd(flow_pkg::OP_RETURN, 11'h000);
			chk(pc, (i < 8) ? 13'h0908 - i[12:0] : 13'h0908);
		end
		rd_chk(8'h8A, 8'h08);
		cmd(flow_pkg::OP_IRQ, 11'h000);
		chk(pc, 13'h0004);
		cmd(flow_pkg::OP_RETURN, 11'h000);
		chk(pc, 13'h0908);
		cmd(flow_pkg::OP_JUMP, 11'h7FF);
		chk(pc, 13'h0FFF);
		cmd(flow_pkg::OP_STEP, 11'h000);
		chk(pc, 13'h1000);
		// call and return on adjacent edges: the return must find pc+1 at once
		@(posedge clk_i);
		go <= 1'b1;
		op <= flow_pkg::OP_CALL;
		tgt <= 11'h055;
		@(posedge clk_i);
		op <= flow_pkg::OP_RETURN;
		@(posedge clk_i);
		go <= 1'b0;
		#1;
		chk(pc, 13'h1001);
		$display("test stack done");
	endtask : t_stack
	task automatic t_irq();
		adc_pulse();
		rd_chk(8'h0C, 8'h40);
		chk(req, 1'b0);
		wr_reg(8'h0C, 8'h00);
		wr_reg(8'h8C, 8'hFF);
		rd_chk(8'h8C, 8'h40);
		wr_reg(8'h0B, 8'hC0);
		chk({global_irq_enable, req}, 2'b10);
		adc_pulse();
		chk(req, 1'b1);
		wr_reg(8'h0B, 8'h80);
		chk(req, 1'b0);
		wr_reg(8'h81, 8'h08);
		chk({prescaler_assign, t0}, 2'b11);
		wr_reg(8'h81, 8'h00);
		chk({prescaler_assign, t0}, 2'b00);
		// conversion and software clear in one cycle: the set must win
		@(posedge clk_i);
		adc <= 1'b1;
		addr <= 8'h0C;
		wdata <= 8'h00;
		wr <= 1'b1;
		@(posedge clk_i);
		adc <= 1'b0;
		wr <= 1'b0;
		#1;
		rd_chk(8'h0C, 8'h40);
		wr_reg(8'h0C, 8'h00);
		rd_chk(8'h0C, 8'h00);
		$display("test irq done");
	endtask : t_irq
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			complete_run();
		end
	end
	initial
	begin
		do_reset(3'b100);
		t_causes();
		t_pc_write();
		t_stack();
		t_irq();
		complete_run();
	end
endmodule : test_program_flow_and_irq_status_regs
bind program_flow_and_irq_status_regs flow_asserts chk_u (.clk_i(clk_i), .srst_i(srst_i),
	.core_cmd_i(core_cmd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .pc_o(pc_o), .fetch_addr_o(fetch_addr_o),
	.periph_irq_request_o(periph_irq_request_o), .prescaler_to_wdt_o(prescaler_to_wdt_o),
	.timer0_rate_1to1_o(timer0_rate_1to1_o));
`default_nettype wire
